// ===== rtl/sram_pins_map.svh
`ifndef SRAM_PINS_MAP_SVH
`define SRAM_PINS_MAP_SVH

// ----------------------------------------------------------------------
// widths of the two configurations, the wide one is built
// ----------------------------------------------------------------------
`define DATA_W_NARROW 18
`define ADDR_W_NARROW 21
`define DATA_W 36
`define ADDR_W 20
`define LANES 4
`define LANE_W 9

// ----------------------------------------------------------------------
// storage and buffering
// ----------------------------------------------------------------------
`define MEM_IDX_W 4
`define MEM_DEPTH 16
`define WQ_DEPTH 16
`define WQ_PTR_W 4

// ----------------------------------------------------------------------
// pin sampling: two stages, deselected and loop-enabled at reset
// ----------------------------------------------------------------------
`define SYNC_W 63
`define SYNC_RST 63'h7f00000000000000

// ----------------------------------------------------------------------
// latency in input clock cycles and clock limits
// ----------------------------------------------------------------------
`define LAT_LOOP_ON 2
`define LAT_LEGACY 1
`define LEGACY_MAX_MHZ 167
`define CLK_SYS_MHZ 250

`endif

// ===== rtl/sram_pins_pkg.sv
`include "sram_pins_map.svh"

package sram_pins_pkg;
   // one data word of the wide configuration
   typedef logic [`DATA_W-1:0] word_t;
   // one set of byte-lane masks, active low
   typedef logic [`LANES-1:0] mask_t;
   // shared address bus
   typedef logic [`ADDR_W-1:0] addr_t;
   // beat phase of the input clock pair, gray along rise -> fall
   typedef enum logic {
      PH_RISE = 1'b0,
      PH_FALL = 1'b1
   } phase_t;
endpackage

// ===== rtl/word_fifo.sv
`timescale 1ns/1ns
`include "sram_pins_map.svh"
module word_fifo #(
   parameter int WIDTH = 100,
   parameter int DEPTH = `WQ_DEPTH
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // ----------------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------------
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] slot_ff [DEPTH]; // entries, no reset needed
   logic [PW-1:0] wr_ptr_ff; // next slot to fill
   logic [PW-1:0] rd_ptr_ff; // oldest slot
   logic [PW:0] count_ff; // occupancy, one bit wider than pointers
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // full and empty come straight from the count
   assign in_ready = (count_ff != DEPTH[PW:0]);
   assign out_valid = (count_ff != '0);
   assign out_data = slot_ff[rd_ptr_ff];

   // ----------------------------------------------------------------------
   // pointer and count update
   // ----------------------------------------------------------------------
   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end

   // entry write, only on an accepted push
   always_ff @(posedge clk_sys) begin
      if (push) begin
         slot_ff[wr_ptr_ff] <= in_data;
      end
   end

   // a push is never taken while full
   chk_no_overflow: assert property (@(posedge clk_sys) disable iff (srst)
      !in_ready && !pop |=> count_ff == DEPTH[PW:0])
      else $error("fifo count moved past full");
endmodule

// ===== rtl/sep_port_ddr_sram_pins.sv
`timescale 1ns/1ns
`include "sram_pins_map.svh"
// Overview of operation
// RQ1: write data taken on both clock rises
// RQ2: write select low at positive rise starts write
// RQ3: deselected write port ignores data, memory kept
// RQ4: byte masks sampled on both beats, active low
// RQ5: masked bytes keep their stored contents
// RQ6: read address positive rise, write address negative
// RQ7: two internal arrays, twenty or 21 address bits
// RQ8: address ignored when its port is deselected
// RQ9: read data beat launched on each rise
// RQ10: read select low at positive rise starts read
// RQ11: finish pending read, then float outputs
// RQ12: valid flag marks data beats, echo aligned
// RQ13: every access begins at positive clock rise
// RQ14: free running complementary echo clocks out
// RQ15: loop disable low selects legacy, slower clock
// RQ16: each access is two words, low first
// RQ17: latency two cycles, one in legacy
// RQ18: first beat at positive rise, rest at negative
// RQ19: reads see newest data, forwarded from write
// RQ20: valid flag low on every beat without data
module sep_port_ddr_sram_pins (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic write_port_sel_n,
   input wire logic read_port_sel_n,
   input wire logic [`LANES-1:0] byte_lane_mask_n,
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic [`DATA_W-1:0] write_data,
   input wire logic delay_loop_disable_n,
   output logic [`DATA_W-1:0] read_data,
   output logic read_data_oe_n,
   output logic read_valid_flag,
   output logic echo_timing_out,
   output logic echo_timing_out_n,
   output logic write_queue_ready
);
   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // per-lane merge: a low mask bit takes the new byte, else keeps old
   function automatic sram_pins_pkg::word_t lane_merge(
      input sram_pins_pkg::word_t old_w,
      input sram_pins_pkg::word_t new_w,
      input sram_pins_pkg::mask_t mask_n);
      sram_pins_pkg::word_t res;
      res = old_w;
      for (int i = 0; i < `LANES; i++) begin
         if (!mask_n[i]) begin
            res[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W];
         end
      end
      return res;
   endfunction

   // storage index from a full bus address
   function automatic logic [`MEM_IDX_W-1:0] mem_index(
      input sram_pins_pkg::addr_t a);
      return a[`MEM_IDX_W-1:0];
   endfunction

   // ----------------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------------
   logic [`SYNC_W-1:0] sync1_ff; // first stage, read only by stage two
   logic [`SYNC_W-1:0] sync2_ff; // stable copy used by the logic
   wire [`SYNC_W-1:0] pin_bus = {write_port_sel_n, read_port_sel_n,
      delay_loop_disable_n, byte_lane_mask_n, addr_in, write_data};

   // all pins share one pair of stages so they stay aligned to a beat
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sync1_ff <= `SYNC_RST;
         sync2_ff <= `SYNC_RST;
      end else begin
         sync1_ff <= pin_bus;
         sync2_ff <= sync1_ff;
      end
   end

   wire s_wsel_n = sync2_ff[62]; // write select, active low
   wire s_rsel_n = sync2_ff[61]; // read select, active low
   wire s_loop_dis_n = sync2_ff[60]; // high: delay loop running
   wire [`LANES-1:0] s_mask_n = sync2_ff[59:56]; // lane masks
   wire [`ADDR_W-1:0] s_addr = sync2_ff[55:36]; // shared address
   wire [`DATA_W-1:0] s_data = sync2_ff[35:0]; // write data beat

   // ----------------------------------------------------------------------
   // beat phase of the input clock pair
   // ----------------------------------------------------------------------
   // each clk_sys edge is one beat; rise beats alternate with fall beats
   sram_pins_pkg::phase_t phase_ff;
   sram_pins_pkg::phase_t nxt_phase;
   assign nxt_phase = (phase_ff == sram_pins_pkg::PH_RISE) ?
      sram_pins_pkg::PH_FALL : sram_pins_pkg::PH_RISE;
   wire at_rise = (phase_ff == sram_pins_pkg::PH_RISE);
   wire at_fall = (phase_ff == sram_pins_pkg::PH_FALL);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase_ff <= sram_pins_pkg::PH_RISE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // ----------------------------------------------------------------------
   // write port capture
   // ----------------------------------------------------------------------
   wire wr_take = at_rise & ~s_wsel_n; // RQ2 RQ13
   logic wr_act_ff; // write in progress, second beat due
   sram_pins_pkg::word_t wd0_ff; // first data beat
   sram_pins_pkg::mask_t wm0_ff; // first beat masks

   // first beat with the select; data ignored when deselected
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_act_ff <= 1'b0;
         wd0_ff <= '0;
         wm0_ff <= '1;
      end else begin
         wr_act_ff <= wr_take; // RQ3
         if (wr_take) begin
            wd0_ff <= s_data; // RQ1 RQ18
            wm0_ff <= s_mask_n; // RQ4
         end
      end
   end

   // second beat, masks and write address complete the entry
   wire wq_in_valid = at_fall & wr_act_ff; // RQ6 RQ18
   wire [99:0] wq_in_data = {s_addr, wd0_ff, wm0_ff, s_data, s_mask_n};
   wire wq_out_valid;
   wire [99:0] wq_out_data;
   wire wq_in_ready;

   // ----------------------------------------------------------------------
   // write queue
   // ----------------------------------------------------------------------
   // drains on rise beats only, since fall beats own the array for reads
   word_fifo #(
      .WIDTH(100),
      .DEPTH(`WQ_DEPTH)
   ) u_write_queue (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(wq_in_valid),
      .in_ready(wq_in_ready),
      .in_data(wq_in_data),
      .out_valid(wq_out_valid),
      .out_ready(at_rise),
      .out_data(wq_out_data)
   );
   assign write_queue_ready = wq_in_ready;

   wire [`ADDR_W-1:0] q_addr = wq_out_data[99:80];
   wire [`DATA_W-1:0] q_d0 = wq_out_data[79:44];
   wire [`LANES-1:0] q_m0 = wq_out_data[43:40];
   wire [`DATA_W-1:0] q_d1 = wq_out_data[39:4];
   wire [`LANES-1:0] q_m1 = wq_out_data[3:0];
   wire commit = wq_out_valid & at_rise;

   // ----------------------------------------------------------------------
   // storage: two arrays, low word and high word of each address
   // ----------------------------------------------------------------------
   // only the low address bits index flops; upper bits alias
   sram_pins_pkg::word_t mem_lo_ff [`MEM_DEPTH]; // RQ7
   sram_pins_pkg::word_t mem_hi_ff [`MEM_DEPTH]; // RQ7

   always_ff @(posedge clk_sys) begin
      if (commit) begin
         mem_lo_ff[mem_index(q_addr)] <=
            lane_merge(mem_lo_ff[mem_index(q_addr)], q_d0, q_m0); // RQ5
         mem_hi_ff[mem_index(q_addr)] <=
            lane_merge(mem_hi_ff[mem_index(q_addr)], q_d1, q_m1); // RQ5
      end
   end

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   wire rd_take = at_rise & ~s_rsel_n; // RQ10 RQ13
   logic rd_pend_ff; // lookup due on the next fall beat
   sram_pins_pkg::addr_t rd_addr_ff; // read address register

   // the address is only stored when the read port is selected
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_pend_ff <= 1'b0;
         rd_addr_ff <= '0;
      end else begin
         rd_pend_ff <= rd_take;
         if (rd_take) begin
            rd_addr_ff <= s_addr; // RQ6 RQ8
         end
      end
   end

   // a write whose second beat lands now is newer than the array
   wire fwd_hit = wr_act_ff & (s_addr == rd_addr_ff); // RQ19
   wire [`DATA_W-1:0] base0 = mem_lo_ff[mem_index(rd_addr_ff)];
   wire [`DATA_W-1:0] base1 = mem_hi_ff[mem_index(rd_addr_ff)];
   wire [`DATA_W-1:0] look0 = fwd_hit ?
      lane_merge(base0, wd0_ff, wm0_ff) : base0; // RQ19
   wire [`DATA_W-1:0] look1 = fwd_hit ?
      lane_merge(base1, s_data, s_mask_n) : base1; // RQ19

   // ----------------------------------------------------------------------
   // latency pipe, one stage per input clock cycle
   // ----------------------------------------------------------------------
   logic st1_v_ff; // burst ready one cycle after the request
   sram_pins_pkg::word_t st1_w0_ff;
   sram_pins_pkg::word_t st1_w1_ff;
   logic st2_v_ff; // burst ready two cycles after the request
   sram_pins_pkg::word_t st2_w0_ff;
   sram_pins_pkg::word_t st2_w1_ff;

   // advances on fall beats so a burst holds still across both beats
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st1_v_ff <= 1'b0;
         st2_v_ff <= 1'b0;
         st1_w0_ff <= '0;
         st1_w1_ff <= '0;
         st2_w0_ff <= '0;
         st2_w1_ff <= '0;
      end else if (at_fall) begin
         st1_v_ff <= rd_pend_ff;
         st1_w0_ff <= look0; // RQ16
         st1_w1_ff <= look1; // RQ16
         st2_v_ff <= st1_v_ff;
         st2_w0_ff <= st1_w0_ff;
         st2_w1_ff <= st1_w1_ff;
      end
   end

   // legacy mode taps the shorter pipe; switching mid-burst is unsafe
   wire legacy = ~s_loop_dis_n; // RQ15
   wire sel_v = legacy ? st1_v_ff : st2_v_ff; // RQ17
   wire [`DATA_W-1:0] sel_w0 = legacy ? st1_w0_ff : st2_w0_ff;
   wire [`DATA_W-1:0] sel_w1 = legacy ? st1_w1_ff : st2_w1_ff;

   // ----------------------------------------------------------------------
   // output registers and echo clocks
   // ----------------------------------------------------------------------
   logic [`DATA_W-1:0] q_ff; // read data beat
   logic valid_ff; // valid flag
   logic oe_n_ff; // low while driving read data
   logic echo_ff; // echo clock, high after each rise beat
   logic echo_n_ff; // complement, own flop so both change together

   // low word on the rise beat, high word on the fall beat
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q_ff <= '0;
         valid_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end else begin
         valid_ff <= sel_v; // RQ12 RQ20
         oe_n_ff <= ~sel_v; // RQ11
         if (sel_v) begin
            q_ff <= at_rise ? sel_w0 : sel_w1; // RQ9 RQ16
         end
      end
   end

   // free running from the phase, so valid edges share echo edges
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         echo_ff <= 1'b0;
         echo_n_ff <= 1'b1;
      end else begin
         echo_ff <= at_rise; // RQ14
         echo_n_ff <= ~at_rise; // RQ14
      end
   end

   assign read_data = q_ff;
   assign read_valid_flag = valid_ff;
   assign read_data_oe_n = oe_n_ff;
   assign echo_timing_out = echo_ff;
   assign echo_timing_out_n = echo_n_ff;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   sequence seq_two_beats;
      valid_ff ##1 valid_ff;
   endsequence

   sequence seq_take_loop_on;
      (rd_take && s_loop_dis_n) ##1 s_loop_dis_n [*4];
   endsequence

   sequence seq_take_legacy;
      (rd_take && !s_loop_dis_n) ##1 !s_loop_dis_n [*2];
   endsequence

   chk_read_lat_on: assert property ( // RQ17
      seq_take_loop_on |=> seq_two_beats)
      else $error("read burst late with loop on");

   chk_read_lat_legacy: assert property ( // RQ17
      seq_take_legacy |=> seq_two_beats)
      else $error("read burst late in legacy mode");

   chk_float_idle: assert property ( // RQ11
      !read_valid_flag |-> read_data_oe_n)
      else $error("read data driven without valid data");

   chk_valid_first_beat: assert property ( // RQ12
      $rose(read_valid_flag) |-> echo_timing_out)
      else $error("valid flag rose off the rise beat");

   chk_echo_pair: assert property ( // RQ14
      echo_timing_out != echo_timing_out_n)
      else $error("echo clocks not complementary");

   chk_echo_running: assert property ( // RQ14
      !srst ##1 1'b1 |-> echo_timing_out != $past(echo_timing_out))
      else $error("echo clock stalled");

   chk_write_push: assert property ( // RQ18
      wr_take |=> wq_in_valid)
      else $error("selected write not queued");

   chk_write_ignored: assert property ( // RQ3
      (at_rise && s_wsel_n) |=> !wq_in_valid)
      else $error("deselected write queued");

   chk_read_ignored: assert property ( // RQ8
      (at_rise && s_rsel_n) |=> !rd_pend_ff ##1 !st1_v_ff)
      else $error("deselected read started");
endmodule

// ===== test/sram_ctrl_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// controller model: drives the request pins between clock edges
// ----------------------------------------------------------------------
module sram_ctrl_model (
   input wire logic clk_sys,
   input wire logic srst,
   output logic write_port_sel_n,
   output logic read_port_sel_n,
   output sram_pins_pkg::mask_t byte_lane_mask_n,
   output sram_pins_pkg::addr_t addr_in,
   output sram_pins_pkg::word_t write_data
);
   int nxt_edge; // index of the coming edge after reset release
   int n_edges; // rising edges since time zero

   // even edge indices are rise beats, odd ones fall beats
   always @(posedge clk_sys) begin
      n_edges <= n_edges + 1;
      nxt_edge <= srst ? 0 : nxt_edge + 1;
   end

   // idle at time zero: both ports deselected
   initial begin
      nxt_edge = 0;
      n_edges = 0;
      write_port_sel_n = 1'b1;
      read_port_sel_n = 1'b1;
      byte_lane_mask_n = 4'hf;
      addr_in = 20'h00000;
      write_data = 36'h000000000;
   end

   // one slot: rise beat values, then fall beat values
   task automatic slot(input logic wr, input logic rd,
         input sram_pins_pkg::addr_t ra, input sram_pins_pkg::addr_t wa,
         input sram_pins_pkg::word_t d0, input sram_pins_pkg::word_t d1,
         input sram_pins_pkg::mask_t m0, input sram_pins_pkg::mask_t m1,
         output int at);
      @(negedge clk_sys);
      // pins land two edges late, so parity is kept as is
      while (nxt_edge[0]) @(negedge clk_sys);
      at = n_edges;
      write_port_sel_n = ~wr;
      read_port_sel_n = ~rd;
      addr_in = ra;
      write_data = d0;
      byte_lane_mask_n = m0;
      @(negedge clk_sys);
      // selects only count on rise beats, so drop them here
      write_port_sel_n = 1'b1;
      read_port_sel_n = 1'b1;
      addr_in = wa;
      write_data = d1;
      byte_lane_mask_n = m1;
   endtask

   // released bus: never leave the last value standing
   task automatic release_pins();
      @(negedge clk_sys);
      addr_in = ~addr_in;
      write_data = ~write_data;
      byte_lane_mask_n = ~byte_lane_mask_n;
   endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ns
`include "sram_pins_map.svh"

module testbench;
   logic clk_sys; // 4 ns period
   logic srst;
   logic delay_loop_disable_n; // low selects legacy timing
   logic write_port_sel_n;
   logic read_port_sel_n;
   sram_pins_pkg::mask_t byte_lane_mask_n;
   sram_pins_pkg::addr_t addr_in;
   sram_pins_pkg::word_t write_data;
   sram_pins_pkg::word_t read_data;
   logic read_data_oe_n;
   logic read_valid_flag;
   logic echo_timing_out;
   logic echo_timing_out_n;
   logic write_queue_ready;
   int mismatches;
   int n_compared;
   int oe_bad; // valid beats seen while outputs float
   sram_pins_pkg::word_t cap_w[$]; // captured read beats
   logic cap_e[$]; // echo level per beat
   int cap_t[$]; // edge count per beat
   sram_pins_pkg::word_t word_a = 36'h123456789;
   sram_pins_pkg::word_t word_b = 36'hfedcba987;
   sram_pins_pkg::word_t word_c = 36'h0f0f0f0f0;
   sram_pins_pkg::word_t word_d = 36'h5a5a5a5a5;

   sep_port_ddr_sram_pins i_sep_port_ddr_sram_pins (.clk_sys, .srst,
      .write_port_sel_n, .read_port_sel_n, .byte_lane_mask_n, .addr_in,
      .write_data, .delay_loop_disable_n, .read_data, .read_data_oe_n,
      .read_valid_flag, .echo_timing_out, .echo_timing_out_n,
      .write_queue_ready);
   sram_ctrl_model ctrl (.clk_sys, .srst, .write_port_sel_n,
      .read_port_sel_n, .byte_lane_mask_n, .addr_in, .write_data);

   // ----------------------------------------------------------------------
   // clock, capture of read beats, watchdog
   // ----------------------------------------------------------------------
   always #2 clk_sys = ~clk_sys;

   // outputs settle after the rising edge, so look at the falling one
   always @(negedge clk_sys) begin
      if (read_valid_flag === 1'b1) begin
         cap_w.push_back(read_data);
         cap_e.push_back(echo_timing_out);
         cap_t.push_back(ctrl.n_edges);
         if (read_data_oe_n !== 1'b0) oe_bad++;
      end
   end

   // whole run is well under two thousand cycles
   initial begin
      #20000;
      mismatches++;
      $display("watchdog ran out");
      summarize();
   end

   // ----------------------------------------------------------------------
   // compare and helper tasks
   // ----------------------------------------------------------------------
   task automatic cmp_word(input string what, input sram_pins_pkg::word_t e,
         input sram_pins_pkg::word_t g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp_bit(input string what, input logic e, input logic g);
      cmp_word(what, {35'h0, e}, {35'h0, g});
   endtask

   task automatic cmp_num(input string what, input int e, input int g);
      n_compared++;
      if (g != e) begin
         mismatches++;
         $display("BAD %s expected %0d seen %0d", what, e, g);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // lanes whose active-low mask is set keep the old contents
   function automatic sram_pins_pkg::word_t merge(
         input sram_pins_pkg::word_t old_w, input sram_pins_pkg::word_t new_w,
         input sram_pins_pkg::mask_t m_n);
      sram_pins_pkg::word_t res;
      res = old_w;
      for (int i = 0; i < `LANES; i++) begin
         if (!m_n[i]) res[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W];
      end
      return res;
   endfunction

   task automatic clear_cap();
      cap_w.delete();
      cap_e.delete();
      cap_t.delete();
      oe_bad = 0;
   endtask

   // one burst at capture index k; two sync edges plus rise to rise
   task automatic judge(input int k, input int at0,
         input sram_pins_pkg::word_t e0, input sram_pins_pkg::word_t e1,
         input int lat);
      if (cap_w.size() < k + 2) begin
         cmp_num("beats", k + 2, cap_w.size());
         return;
      end
      cmp_word("low word", e0, cap_w[k]);
      cmp_word("high word", e1, cap_w[k+1]);
      cmp_bit("echo low", 1'b1, cap_e[k]);
      cmp_bit("echo high", 1'b0, cap_e[k+1]);
      cmp_num("latency", 3 + 2 * lat, cap_t[k] - at0);
      cmp_num("pair gap", 1, cap_t[k+1] - cap_t[k]);
   endtask

   // read a burst and check it, the float after it and quiet beats
   task automatic rd(input sram_pins_pkg::addr_t ra,
         input sram_pins_pkg::word_t e0, input sram_pins_pkg::word_t e1,
         input int lat);
      int at;
      clear_cap();
      ctrl.slot(1'b0, 1'b1, ra, ~ra, e1, e0, 4'h0, 4'h0, at);
      ctrl.release_pins();
      repeat (16) @(negedge clk_sys);
      judge(0, at, e0, e1, lat);
      cmp_num("burst beats", 2, cap_w.size());
      cmp_num("floating beats", 0, oe_bad);
      cmp_bit("outputs floated", 1'b1, read_data_oe_n);
   endtask

   task automatic wr(input sram_pins_pkg::addr_t wa,
         input sram_pins_pkg::word_t d0, input sram_pins_pkg::word_t d1,
         input sram_pins_pkg::mask_t m0, input sram_pins_pkg::mask_t m1);
      int at;
      ctrl.slot(1'b1, 1'b0, ~wa, wa, d0, d1, m0, m1, at);
      ctrl.release_pins();
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_echo();
      repeat (4) begin
         @(negedge clk_sys);
         cmp_bit("echo", ctrl.nxt_edge[0], echo_timing_out);
         cmp_bit("echo pair", ~echo_timing_out, echo_timing_out_n);
      end
      cmp_bit("queue ready", 1'b1, write_queue_ready);
      $display("test echo done");
   endtask

   task automatic t_mask();
      wr(20'h00005, word_a, word_b, 4'h0, 4'h0);
      rd(20'h00005, word_a, word_b, `LAT_LOOP_ON);
      wr(20'h00005, word_c, word_d, 4'ha, 4'h5);
      rd(20'h00005, merge(word_a, word_c, 4'ha),
         merge(word_b, word_d, 4'h5), `LAT_LOOP_ON);
      $display("test mask done");
   endtask

   // deselected write with live data; legacy read of the same place
   task automatic t_desel_legacy();
      int at;
      ctrl.slot(1'b0, 1'b0, 20'h00005, 20'h00005, word_b, word_a, 4'h0,
         4'h0, at);
      ctrl.release_pins();
      // legacy runs at the system rate here; the slower limit is not kept
      delay_loop_disable_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      rd(20'h00005, merge(word_a, word_c, 4'ha),
         merge(word_b, word_d, 4'h5), `LAT_LEGACY);
      delay_loop_disable_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      $display("test deselect legacy done");
   endtask

   // read and write of one place in the same slot get the new data
   task automatic t_fwd();
      int at;
      clear_cap();
      ctrl.slot(1'b1, 1'b1, 20'h00009, 20'h00009, word_c, word_a, 4'h0,
         4'h0, at);
      ctrl.release_pins();
      repeat (16) @(negedge clk_sys);
      judge(0, at, word_c, word_a, `LAT_LOOP_ON);
      $display("test forward done");
   endtask

   task automatic t_b2b();
      int at;
      int at2;
      wr(20'h00003, word_a, word_d, 4'h0, 4'h0);
      wr(20'h00004, word_b, word_c, 4'h0, 4'h0);
      clear_cap();
      ctrl.slot(1'b0, 1'b1, 20'h00003, 20'h0, 36'h0, 36'h0, 4'h0, 4'h0, at);
      ctrl.slot(1'b0, 1'b1, 20'h00004, 20'h0, 36'h0, 36'h0, 4'h0, 4'h0, at2);
      ctrl.release_pins();
      repeat (16) @(negedge clk_sys);
      judge(0, at, word_a, word_d, `LAT_LOOP_ON);
      judge(2, at2, word_b, word_c, `LAT_LOOP_ON);
      cmp_num("b2b beats", 4, cap_w.size());
      cmp_bit("b2b floated", 1'b1, read_data_oe_n);
      $display("test back to back done");
   endtask

   // writes back to back, one place twice: the queue keeps their order
   task automatic t_fifo();
      int at;
      int busy;
      busy = 0;
      ctrl.slot(1'b1, 1'b0, 20'h0, 20'h0000a, word_b, word_c, 4'h0, 4'h0, at);
      if (write_queue_ready !== 1'b1) busy++;
      ctrl.slot(1'b1, 1'b0, 20'h0, 20'h0000b, word_c, word_d, 4'h0, 4'h0, at);
      if (write_queue_ready !== 1'b1) busy++;
      ctrl.slot(1'b1, 1'b0, 20'h0, 20'h0000a, word_d, word_a, 4'h0, 4'h0, at);
      ctrl.release_pins();
      cmp_num("queue stalls", 0, busy);
      rd(20'h0000a, word_d, word_a, `LAT_LOOP_ON);
      rd(20'h0000b, word_c, word_d, `LAT_LOOP_ON);
      cmp_bit("queue ready", 1'b1, write_queue_ready);
      $display("test queue order done");
   endtask

   initial begin
      clk_sys = 1'b0;
      srst = 1'b1;
      delay_loop_disable_n = 1'b1;
      mismatches = 0;
      n_compared = 0;
      oe_bad = 0;
      repeat (20) @(negedge clk_sys);
      srst = 1'b0;
      t_echo();
      t_mask();
      t_desel_legacy();
      t_fwd();
      t_b2b();
      t_fifo();
      summarize();
   end
endmodule
